// ==== core/wdg_map.svh ====
// register layout, reset values and timing constants of the watchdog
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH
`define WDG_CTRL_RESET 8'h7F
`define WDG_ACT_POS 7
`define WDG_TOP_POS 6
`define WDG_ROLL_COUNT 7'h40
`define WDG_PRESCALE_CYCLES 16384
`define WDG_PRESCALE_W 14
`define WDG_RST_PULSE_NS 500
`define WDG_CLK_PERIOD_NS 50
`define WDG_RST_PULSE_CYCLES ((`WDG_RST_PULSE_NS + `WDG_CLK_PERIOD_NS - 1) / `WDG_CLK_PERIOD_NS)
`define WDG_PULSE_W 4
`define WDG_TB_2MS_MSB 4
`define WDG_TB_2MS_LSB 59
`define WDG_TB_4MS_MSB 8
`define WDG_TB_4MS_LSB 53
`define WDG_TB_10MS_MSB 20
`define WDG_TB_10MS_LSB 35
`define WDG_TB_25MS_MSB 49
`define WDG_TB_25MS_LSB 54
`endif

// ==== core/wdg_pkg.sv ====
// types shared by the watchdog files
package wdg_pkg;
    typedef struct packed {
        logic activation_bit;
        logic [6:0] count;
    } watchdog_ctrl_t;
    typedef struct packed {
        logic [5:0] msb_const;
        logic [5:0] lsb_const;
    } timebase_consts_t;
    typedef enum logic [1:0] {RUN, PULSE} rst_state_t;
endpackage

// ==== core/wdg_prescaler.sv ====
// free-running prescaler giving one tick per 16384 clocks
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.svh"
module wdg_prescaler
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    output logic tick
);
    logic [`WDG_PRESCALE_W-1:0] cnt_q;
    // never cleared by register writes, so timeout has min and max
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= '0;
        else if (run)
            cnt_q <= cnt_q + 1'b1;
    end
    assign tick = run && (cnt_q == {`WDG_PRESCALE_W{1'b1}});
endmodule
`default_nettype wire

// ==== core/windowed_free_running_watchdog.sv ====
// watchdog: control register, down-counter and chip reset request
// Function
// - counter decrements once every 16384 oscillator cycles
// - active and count crosses 40h to 3Fh: reset pin low about 500 ns
// - counter keeps counting even when watchdog not active
// - lower six count bits set the timeout in 64 steps
// - register write never clears the prescaler
// - disabled after reset unless hardware watchdog option set; once active only reset deactivates it
// - write with activation set and top bit clear resets at once
// - halt instruction while active causes reset, per halt option
// - option chooses whether halt causes a watchdog reset
// - option selects hardware watchdog mode
// - timebase select gives prescaler phase constants 4/59 8/53 20/35 49/54
// - minimum timeout formula uses 16384 per count and (192+low)*64
// - register resets to 7Fh
// - activation bit set by software, cleared only by reset
// - hardware watchdog mode: always active, activation bit ignored
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.svh"
module windowed_free_running_watchdog
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic halt_exec,
    input wire logic halt_reset_option,
    input wire logic hw_watchdog_option,
    input wire logic active_halt,
    input wire logic [1:0] timebase_select,
    output logic [7:0] ctrl_rdata,
    output logic reset_n_out,
    output logic reset_req,
    output logic [5:0] tb_msb_const,
    output logic [5:0] tb_lsb_const
);
    watchdog_ctrl_t ctrl_q;
    watchdog_ctrl_t ctrl_d;
    rst_state_t state_q;
    rst_state_t state_d;
    logic [`WDG_PULSE_W-1:0] pulse_q;
    logic [`WDG_PULSE_W-1:0] pulse_d;
    logic prescale_run;
    logic tick;
    logic active;
    logic wr_act_bit;
    logic wr_top_bit;
    logic [`WDG_TOP_POS:0] wr_count;
    logic [`WDG_TOP_POS:0] dec_count;
    logic at_roll_value;
    logic running;
    logic wr_fire;
    logic roll_fire;
    logic halt_fire;
    logic fire;
    logic pulse_done;
    logic reset_n_out_d;
    logic reset_req_d;
    timebase_consts_t tb_c;

    // phase constants for the timebase, used in timeout estimation
    function automatic timebase_consts_t tb_lookup(input logic [1:0] sel);
        unique case (sel)
            2'b00: tb_lookup = '{6'(`WDG_TB_2MS_MSB), 6'(`WDG_TB_2MS_LSB)};
            2'b01: tb_lookup = '{6'(`WDG_TB_4MS_MSB), 6'(`WDG_TB_4MS_LSB)};
            2'b10: tb_lookup = '{6'(`WDG_TB_10MS_MSB), 6'(`WDG_TB_10MS_LSB)};
            2'b11: tb_lookup = '{6'(`WDG_TB_25MS_MSB), 6'(`WDG_TB_25MS_LSB)};
        endcase
    endfunction

    // active-halt freezes the prescaler and with it the counter
    assign prescale_run = !active_halt;

    // prescaler is free running; register writes never reset it
    wdg_prescaler u_pre (
        .clk(clk),
        .arst_n(arst_n),
        .run(prescale_run),
        .tick(tick)
    );

    // write data split into its fields
    assign wr_act_bit = ctrl_wdata[`WDG_ACT_POS];
    assign wr_top_bit = ctrl_wdata[`WDG_TOP_POS];
    assign wr_count = ctrl_wdata[`WDG_TOP_POS:0];

    // armed by the software bit, or by the hardware option which ignores that bit
    assign active = ctrl_q.activation_bit || hw_watchdog_option;

    // one step down, and the value whose step clears the top bit
    assign dec_count = ctrl_q.count - 1'b1;
    assign at_roll_value = (ctrl_q.count == `WDG_ROLL_COUNT);

    // firing conditions; a write in the same cycle as a tick wins
    assign roll_fire = active && tick && !ctrl_wr && at_roll_value;
    assign wr_fire = ctrl_wr && (wr_act_bit || active) && !wr_top_bit;
    assign halt_fire = active && halt_exec && halt_reset_option;

    // requests raised while a pulse runs are dropped, so pulses never overlap
    assign running = (state_q == RUN);
    assign fire = running && (roll_fire || wr_fire || halt_fire);
    assign pulse_done = (pulse_q == '0);

    // phase constants of the selected timebase
    assign tb_c = tb_lookup(timebase_select);

    // next values of the registered reset outputs
    assign reset_n_out_d = (state_d != PULSE);
    assign reset_req_d = fire;

    // register next value: a write replaces the count, otherwise a tick steps it
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (ctrl_wr)
        begin
            ctrl_d.count = wr_count;
            ctrl_d.activation_bit = ctrl_q.activation_bit | wr_act_bit;
        end
        else if (tick)
            ctrl_d.count = dec_count;
    end

    // reset pulse sequencer; an illegal state code falls back to idle
    always_comb
    begin
        state_d = state_q;
        pulse_d = pulse_q;
        unique case (state_q)
            RUN:
                if (fire)
                begin
                    state_d = PULSE;
                    pulse_d = `WDG_PULSE_W'(`WDG_RST_PULSE_CYCLES - 1);
                end
            PULSE:
                if (pulse_done)
                    state_d = RUN;
                else
                    pulse_d = pulse_q - 1'b1;
            default:
                state_d = RUN;
        endcase
    end

    // control register; chip reset reinitialises it through arst_n
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= `WDG_CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // sequencer state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= RUN;
        else
            state_q <= state_d;
    end

    // pulse length counter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pulse_q <= '0;
        else
            pulse_q <= pulse_d;
    end

    // readback copy of the control register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_rdata <= `WDG_CTRL_RESET;
        else
            ctrl_rdata <= ctrl_d;
    end

    // reset pin, high while idle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_n_out <= 1'b1;
        else
            reset_n_out <= reset_n_out_d;
    end

    // one-cycle request into the chip reset logic
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_req <= 1'b0;
        else
            reset_req <= reset_req_d;
    end

    // upper timebase constant for timeout estimation
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tb_msb_const <= '0;
        else
            tb_msb_const <= tb_c.msb_const;
    end

    // lower timebase constant for timeout estimation
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tb_lsb_const <= '0;
        else
            tb_lsb_const <= tb_c.lsb_const;
    end

endmodule
`default_nettype wire

// ==== tb/wdg_checker_properties.sv ====
// port assertions for the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdg_checker
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [1:0] timebase_select,
    input wire logic [7:0] ctrl_rdata,
    input wire logic reset_n_out,
    input wire logic reset_req,
    input wire logic [5:0] tb_msb_const,
    input wire logic [5:0] tb_lsb_const
);
    // one clock domain for every check
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_REQ_PIN: assert property (reset_req |-> !reset_n_out) else $error("req pin");
    AST_ONE_PULSE: assert property (reset_req |=> !reset_req) else $error("req len");
    AST_PIN_LEN: assert property ($fell(reset_n_out) |-> !reset_n_out[*8] ##1 !reset_n_out[*2] ##1 reset_n_out)
        else $error("pin len");
    AST_FELL_REQ: assert property ($fell(reset_n_out) |-> reset_req) else $error("pin cause");
    AST_SOFT_RST: assert property (ctrl_wr && ctrl_wdata[7] && !ctrl_wdata[6] && reset_n_out |=> reset_req)
        else $error("soft rst");
    AST_LOAD: assert property (ctrl_wr && ctrl_wdata[6] |=> ctrl_rdata[6:0] == $past(ctrl_wdata[6:0]))
        else $error("load");
    AST_STICKY: assert property (ctrl_rdata[7] |=> ctrl_rdata[7]) else $error("sticky");
    AST_TB_CONST: assert property (timebase_select == 2'h3 |=> tb_msb_const == 6'h31 && tb_lsb_const == 6'h36)
        else $error("const");
endmodule
bind windowed_free_running_watchdog wdg_checker chk_u (.clk(clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .timebase_select(timebase_select), .ctrl_rdata(ctrl_rdata),
    .reset_n_out(reset_n_out), .reset_req(reset_req), .tb_msb_const(tb_msb_const), .tb_lsb_const(tb_lsb_const));
`default_nettype wire

// ==== tb/windowed_free_running_watchdog_bench.sv ====
// self-checking bench for the watchdog
`timescale 1ns/1ps
`default_nettype none
module windowed_free_running_watchdog_bench;
    logic clk = 0, arst_n = 0, wr = 0, halt = 0, hopt = 0, hw = 0, rn, rq;
    logic [7:0] wd = 8'h00, rd;
    logic [1:0] ts = 2'h0;
    logic [5:0] km, kl;
    logic [7:0] mt [4] = '{8'h04, 8'h08, 8'h14, 8'h31};
    logic [7:0] lt [4] = '{8'h3b, 8'h35, 8'h23, 8'h36};
    int miscompares = 0, checks_done = 0;
    always #25 clk = ~clk;
    windowed_free_running_watchdog dut_u (.clk(clk), .arst_n(arst_n), .ctrl_wr(wr), .ctrl_wdata(wd),
        .halt_exec(halt), .halt_reset_option(hopt), .hw_watchdog_option(hw), .active_halt(1'b0),
        .timebase_select(ts), .ctrl_rdata(rd), .reset_n_out(rn), .reset_req(rq), .tb_msb_const(km),
        .tb_lsb_const(kl));
    // value compare, counting mismatches
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // reset for three cycles
    task automatic rst();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
    endtask
    // one write strobe, returns with read data settled
    task automatic put(input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // one halt pulse with the given option
    task automatic hit(input logic o);
        @(posedge clk);
        halt <= 1'b1;
        hopt <= o;
        @(posedge clk);
        halt <= 1'b0;
    endtask
    // bounded watch for a reset request
    task automatic wait_req(input int n, input logic e);
        logic s;
        s = 1'b0;
        repeat (n)
        begin
            #1 s = s | (rq === 1'b1);
            @(posedge clk);
        end
        chk({7'h00, s}, {7'h00, e});
        $display("step done %0t", $time);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        rst();
        #1 chk(rd, 8'h7f);
        repeat (16385) @(posedge clk);
        #1 chk(rd, 8'h7e);
        $display("test free run done %0t", $time);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            ts <= i[1:0];
            repeat (3) @(posedge clk);
            #1 chk({2'h0, km}, mt[i]);
            chk({2'h0, kl}, lt[i]);
        end
        $display("test timebase done %0t", $time);
        put(8'hc5);
        chk(rd, 8'hc5);
        put(8'h45);
        chk(rd, 8'hc5);
        repeat (16365) @(posedge clk);
        #1 chk(rd, 8'hc4);
        $display("test load and prescaler done %0t", $time);
        put(8'hc0);
        wait_req(16400, 1'b1);
        rst();
        #1 chk(rd, 8'h7f);
        put(8'h80);
        wait_req(3, 1'b1);
        repeat (6) @(posedge clk);
        #1 chk({7'h00, rn}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, rn}, 8'h01);
        rst();
        put(8'hff);
        hit(1'b0);
        wait_req(3, 1'b0);
        hit(1'b1);
        wait_req(3, 1'b1);
        rst();
        hw <= 1'b1;
        hit(1'b1);
        wait_req(3, 1'b1);
        report_and_stop();
    end
    // hang guard
    initial
    begin
        #3000000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
